// file: core/nvmac_consts.svh
// constants and offsets for the nonvolatile memory access control block
// Summary of operation
// RQ1 - go with region 00 programs EEPROM byte
// RQ2 - go with region 10, space 0 writes flash
// RQ3 - go with region x1, space 1 writes config
// RQ4 - operations self-timed; go clears when done
// RQ5 - writing zero to go never aborts
// RQ6 - go accepted only right after unlock
// RQ7 - fetch reads selected location into data
// RQ8 - fetch set by software, cleared by hardware
// RQ9 - software uses erase only for flash
// RQ10 - error flag cleared only by software
// RQ11 - unlock key register reads all zeros
// RQ12 - address ten bits, high two optional
// RQ13 - data holds read byte, supplies written
// RQ14 - pointer bit 21 selects config space
// RQ15 - pointer is upper, high, low fields
// RQ16 - latch gets table reads, holds writes
// RQ17 - region 00 eeprom, 10 flash, x1 config
// RQ18 - program enable gates all program cycles
// RQ19 - erase select picks erase over write
// RQ20 - error set on bad address or reset
// RQ21 - two key bytes consecutively, then go
`ifndef NVMAC_CONSTS_SVH
`define NVMAC_CONSTS_SVH
`define NVMAC_ADDR_W 12
`define NVMAC_OFF_ADR_LOW 12'h0f7e
`define NVMAC_OFF_ADR_HIGH 12'h0f7f
`define NVMAC_OFF_DATA 12'h0f80
`define NVMAC_OFF_CTRL 12'h0f81
`define NVMAC_OFF_KEY 12'h0f82
`define NVMAC_OFF_LATCH 12'h0ff5
`define NVMAC_OFF_PTR_LOW 12'h0ff6
`define NVMAC_OFF_PTR_HIGH 12'h0ff7
`define NVMAC_OFF_PTR_UPPER 12'h0ff8
`define NVMAC_KEY_FIRST 8'h0055
`define NVMAC_KEY_SECOND 8'h00aa
`define NVMAC_BIT_FETCH 0
`define NVMAC_BIT_GO 1
`define NVMAC_BIT_PEN 2
`define NVMAC_BIT_ERR 3
`define NVMAC_BIT_ERASE 4
`define NVMAC_PROG_TIME_US 2000
`define NVMAC_CLK_MHZ 10
`define NVMAC_PROG_CYCLES (`NVMAC_PROG_TIME_US * `NVMAC_CLK_MHZ)
`define NVMAC_REG_RESET 8'h0000
`endif

// file: core/nvmac_mem.sv
// small byte memory standing in for the eeprom, flash and config arrays
`timescale 1ns/10ps
`default_nettype none
module nvmac_mem
   import nvmac_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   // clock
   input wire logic core_clk,
   // access
   nvmac_mem_if.mem bus
);
   logic [7:0] store_reg [0:(1<<ADDR_W)-1];
   logic [7:0] rdata_reg;
   always_ff @(posedge core_clk) begin
      if (bus.wr_en) begin
         store_reg[bus.addr[ADDR_W-1:0]] <= bus.wdata;
      end
   end
   always_ff @(posedge core_clk) begin
      rdata_reg <= store_reg[bus.addr[ADDR_W-1:0]];
   end
   assign bus.rdata = rdata_reg;
endmodule // nvmac_mem
`default_nettype wire

// file: core/nvmac_mem_if.sv
// carrier between the control block and its byte storage
`timescale 1ns/10ps
`default_nettype none
interface nvmac_mem_if;
   logic wr_en;
   logic [23:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   modport ctrl (output wr_en, output addr, output wdata, input rdata);
   modport mem (input wr_en, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// file: core/nvmac_pkg.sv
// types of the nonvolatile memory access control block
package nvmac_pkg;
   typedef enum logic [3:0] {
      NVMAC_IDLE = 4'b0001,
      NVMAC_PROG = 4'b0010,
      NVMAC_READ = 4'b0100,
      NVMAC_RDWAIT = 4'b1000
   } nvmac_state_type;
   typedef enum logic [1:0] {
      NVMAC_REG_EEPROM = 2'b00,
      NVMAC_REG_FLASH = 2'b10
   } nvmac_region_type;
endpackage

// file: core/nvmac_top.sv
// register control of nonvolatile memory: program, erase, read, table access
//
// Added by the designer: the strobed register port.
`include "nvmac_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module nvmac_top
   import nvmac_pkg::*;
#(
   parameter int PROG_CYCLES = `NVMAC_PROG_CYCLES,
   parameter bit WIDE_ADDR = 1'b0,
   parameter int MEM_ADDR_W = 8
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // register port
   input wire logic [11:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // table instruction strobes
   input wire logic table_read_op,
   input wire logic table_write_op,
   // reset-interrupted-write marker, from the reset controller
   input wire logic write_aborted_by_reset,
   // status
   output logic busy
);
   localparam logic [31:0] PROG_LAST = 32'(PROG_CYCLES - 1);

   ////////////////////////////////////////////////////////////////////////////
   // registers
   logic [9:0] eeprom_address_reg;
   logic [7:0] eeprom_data_reg;
   logic [7:0] table_latch_reg;
   logic [21:0] table_pointer_reg;
   logic [1:0] region_select_reg;
   logic erase_select_reg;
   logic write_error_flag_reg;
   logic program_enable_reg;
   logic program_go_reg;
   logic fetch_go_reg;
   logic [1:0] key_stage_reg;
   logic [31:0] timer_reg;
   logic [7:0] reg_rdata_next;
   logic busy_reg;
   logic [7:0] wlatch_reg;
   logic abort_s1_reg;
   logic abort_s2_reg;
   logic abort_seen_reg;
   nvmac_state_type state_reg;
   nvmac_mem_if mem_bus ();

   logic wr_ctrl;
   logic go_request;
   logic config_space_select;
   logic region_ok;
   logic go_start;
   logic bad_start;
   logic fetch_start;

   assign config_space_select = table_pointer_reg[21]; // RQ14
   assign wr_ctrl = reg_wr && (reg_addr == `NVMAC_OFF_CTRL);
   assign go_request = wr_ctrl && reg_wdata[`NVMAC_BIT_GO] && !program_go_reg;
   // region of the go write and pointer space must agree, except for eeprom
   always_comb begin
      region_ok = 1'b0;
      if (reg_wdata[7:6] == NVMAC_REG_EEPROM) begin
         region_ok = 1'b1; // RQ1 RQ17
      end else if (reg_wdata[7:6] == NVMAC_REG_FLASH) begin
         region_ok = !config_space_select; // RQ2
      end else if (reg_wdata[6]) begin
         region_ok = config_space_select; // RQ3
      end
   end
   // key pair just written, enable written high, idle
   assign go_start = go_request && (key_stage_reg == 2'd2) && reg_wdata[`NVMAC_BIT_PEN]
      && (state_reg == NVMAC_IDLE) && region_ok; // RQ6 RQ18 RQ21
   assign bad_start = go_request && (key_stage_reg == 2'd2) && reg_wdata[`NVMAC_BIT_PEN]
      && !region_ok; // RQ20
   assign fetch_start = wr_ctrl && reg_wdata[`NVMAC_BIT_FETCH] && !fetch_go_reg
      && (state_reg == NVMAC_IDLE) && !go_request;

   ////////////////////////////////////////////////////////////////////////////
   // unlock sequence tracker
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         key_stage_reg <= 2'd0;
      end else if (reg_wr && reg_addr == `NVMAC_OFF_KEY) begin
         if (key_stage_reg == 2'd0 && reg_wdata == `NVMAC_KEY_FIRST) begin
            key_stage_reg <= 2'd1; // RQ21
         end else if (key_stage_reg == 2'd1 && reg_wdata == `NVMAC_KEY_SECOND) begin
            key_stage_reg <= 2'd2; // RQ21
         end else begin
            key_stage_reg <= 2'd0;
         end
      end else begin
         key_stage_reg <= 2'd0; // RQ21
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // abort marker synchroniser
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         abort_s1_reg <= 1'b0;
         abort_s2_reg <= 1'b0;
      end else begin
         abort_s1_reg <= write_aborted_by_reset;
         abort_s2_reg <= abort_s1_reg;
      end
   end
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         abort_seen_reg <= 1'b0;
      end else begin
         abort_seen_reg <= abort_s2_reg;
      end
   end
   // one-cycle pulse on the rising marker
   logic abort_edge;
   assign abort_edge = abort_s2_reg && !abort_seen_reg; // RQ20

   ////////////////////////////////////////////////////////////////////////////
   // control register fields
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         region_select_reg <= 2'b00;
         erase_select_reg <= 1'b0;
         program_enable_reg <= 1'b0;
      end else if (wr_ctrl) begin
         region_select_reg <= reg_wdata[7:6];
         program_enable_reg <= reg_wdata[`NVMAC_BIT_PEN];
         if (reg_wdata[`NVMAC_BIT_ERASE]) begin
            erase_select_reg <= 1'b1;
         end
      end else if (state_reg == NVMAC_PROG && timer_reg == PROG_LAST) begin
         erase_select_reg <= 1'b0;
      end
   end

   // error flag: hardware set wins over software write
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         write_error_flag_reg <= 1'b0;
      end else if (bad_start || abort_edge) begin
         write_error_flag_reg <= 1'b1; // RQ20
      end else if (wr_ctrl) begin
         write_error_flag_reg <= reg_wdata[`NVMAC_BIT_ERR]; // RQ10
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sequencer
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= NVMAC_IDLE;
         timer_reg <= 32'h0000_0000;
         program_go_reg <= 1'b0;
         fetch_go_reg <= 1'b0;
      end else begin
         case (state_reg)
            NVMAC_IDLE: begin
               timer_reg <= 32'h0000_0000;
               if (go_start) begin
                  state_reg <= NVMAC_PROG; // RQ1 RQ2 RQ3
                  program_go_reg <= 1'b1;
               end else if (fetch_start) begin
                  state_reg <= NVMAC_READ; // RQ7
                  fetch_go_reg <= 1'b1; // RQ8
               end
            end
            NVMAC_PROG: begin
               // zero writes to go are ignored here
               if (timer_reg == PROG_LAST) begin
                  state_reg <= NVMAC_IDLE;
                  program_go_reg <= 1'b0; // RQ4 RQ5
               end else begin
                  timer_reg <= timer_reg + 32'h0000_0001; // RQ4
               end
            end
            NVMAC_READ: begin
               state_reg <= NVMAC_RDWAIT;
            end
            NVMAC_RDWAIT: begin
               state_reg <= NVMAC_IDLE;
               fetch_go_reg <= 1'b0; // RQ8
            end
            default: begin
               state_reg <= NVMAC_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // storage access
   logic [23:0] mem_addr;
   logic [23:0] start_addr;
   logic [7:0] start_byte;
   logic start_erase;
   logic [23:0] op_addr_reg;
   logic [7:0] op_data_reg;

   always_comb begin
      if (region_select_reg == NVMAC_REG_EEPROM) begin
         mem_addr = {14'h0000, eeprom_address_reg};
      end else begin
         mem_addr = {2'b00, table_pointer_reg};
      end
   end

   // erase writes ff; flash rows take the write latch byte
   assign start_erase = erase_select_reg || reg_wdata[`NVMAC_BIT_ERASE]; // RQ19
   always_comb begin
      if (reg_wdata[7:6] == NVMAC_REG_EEPROM) begin
         start_addr = {14'h0000, eeprom_address_reg}; // RQ1
         start_byte = eeprom_data_reg; // RQ13
      end else begin
         start_addr = {2'b00, table_pointer_reg}; // RQ2 RQ3
         start_byte = wlatch_reg; // RQ16
      end
      if (start_erase) begin
         start_byte = 8'hff; // RQ19
      end
   end

   // snapshot at start, so register writes cannot disturb a running cycle
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         op_addr_reg <= 24'h00_0000;
      end else if (go_start) begin
         op_addr_reg <= start_addr; // RQ5
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         op_data_reg <= 8'h00;
      end else if (go_start) begin
         op_data_reg <= start_byte; // RQ5
      end
   end

   assign mem_bus.addr = (state_reg == NVMAC_PROG) ? op_addr_reg : mem_addr;
   assign mem_bus.wdata = op_data_reg;
   assign mem_bus.wr_en = (state_reg == NVMAC_PROG) && (timer_reg == PROG_LAST);
   nvmac_mem #(.ADDR_W(MEM_ADDR_W)) u_mem (
      .core_clk(core_clk),
      .bus(mem_bus)
   );

   ////////////////////////////////////////////////////////////////////////////
   // address, data, pointer and latch
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         eeprom_address_reg <= 10'h000;
      end else if (reg_wr && reg_addr == `NVMAC_OFF_ADR_LOW) begin
         eeprom_address_reg[7:0] <= reg_wdata;
      end else if (reg_wr && reg_addr == `NVMAC_OFF_ADR_HIGH && WIDE_ADDR) begin
         eeprom_address_reg[9:8] <= reg_wdata[1:0]; // RQ12
      end
   end
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         eeprom_data_reg <= `NVMAC_REG_RESET;
      end else if (state_reg == NVMAC_RDWAIT) begin
         eeprom_data_reg <= mem_bus.rdata; // RQ7 RQ13
      end else if (reg_wr && reg_addr == `NVMAC_OFF_DATA) begin
         eeprom_data_reg <= reg_wdata;
      end
   end

   logic tr_wait_reg;
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         tr_wait_reg <= 1'b0;
      end else begin
         tr_wait_reg <= table_read_op && state_reg == NVMAC_IDLE;
      end
   end
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         table_latch_reg <= `NVMAC_REG_RESET;
      end else if (tr_wait_reg) begin
         table_latch_reg <= mem_bus.rdata; // RQ16
      end else if (reg_wr && reg_addr == `NVMAC_OFF_LATCH) begin
         table_latch_reg <= reg_wdata;
      end
   end
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         wlatch_reg <= `NVMAC_REG_RESET;
      end else if (table_write_op) begin
         wlatch_reg <= table_latch_reg; // RQ16
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         table_pointer_reg <= 22'h00_0000;
      end else if (reg_wr) begin
         case (reg_addr)
            `NVMAC_OFF_PTR_LOW: table_pointer_reg[7:0] <= reg_wdata; // RQ15
            `NVMAC_OFF_PTR_HIGH: table_pointer_reg[15:8] <= reg_wdata; // RQ15
            `NVMAC_OFF_PTR_UPPER: table_pointer_reg[21:16] <= reg_wdata[5:0]; // RQ15
            default: table_pointer_reg <= table_pointer_reg;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read mux
   always_comb begin
      reg_rdata_next = 8'h00;
      case (reg_addr)
         `NVMAC_OFF_ADR_LOW: reg_rdata_next = eeprom_address_reg[7:0];
         `NVMAC_OFF_ADR_HIGH: reg_rdata_next = {6'h00, eeprom_address_reg[9:8]};
         `NVMAC_OFF_DATA: reg_rdata_next = eeprom_data_reg;
         `NVMAC_OFF_CTRL: reg_rdata_next = {region_select_reg, 1'b0, erase_select_reg,
            write_error_flag_reg, program_enable_reg, program_go_reg, fetch_go_reg};
         `NVMAC_OFF_KEY: reg_rdata_next = 8'h00; // RQ11
         `NVMAC_OFF_LATCH: reg_rdata_next = table_latch_reg;
         `NVMAC_OFF_PTR_LOW: reg_rdata_next = table_pointer_reg[7:0];
         `NVMAC_OFF_PTR_HIGH: reg_rdata_next = table_pointer_reg[15:8];
         `NVMAC_OFF_PTR_UPPER: reg_rdata_next = {2'b00, table_pointer_reg[21:16]};
         default: reg_rdata_next = 8'h00;
      endcase
   end
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= reg_rdata_next;
      end else begin
         reg_rdata <= 8'h00;
      end
   end
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         busy_reg <= 1'b0;
      end else begin
         busy_reg <= (state_reg != NVMAC_IDLE) || go_start || fetch_start;
      end
   end
   assign busy = busy_reg;
endmodule // nvmac_top
`default_nettype wire

// file: verification/nvm_access_control_bench.sv
// self-checking bench for the nonvolatile memory access control block
`timescale 1ns/10ps
`default_nettype none
module nvm_access_control_bench;
   logic core_clk = 1'b0;
   logic resetn = 1'b0;
   logic [11:0] reg_addr = 12'h000;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic table_read_op = 1'b0;
   logic table_write_op = 1'b0;
   logic abort_req = 1'b0;
   logic write_aborted_by_reset;
   logic [7:0] reg_rdata;
   logic busy;
   int n_mismatch = 0;
   int num_checks = 0;
   int cyc = 0;
   nvmac_top #(.PROG_CYCLES(8)) u_dut (.core_clk(core_clk), .resetn(resetn),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .table_read_op(table_read_op), .table_write_op(table_write_op),
      .write_aborted_by_reset(write_aborted_by_reset), .busy(busy));
   nvmac_rst_model u_rst (.abort_req(abort_req),
      .write_aborted_by_reset(write_aborted_by_reset));
   initial begin
      forever #50 core_clk = ~core_clk;
   end
   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_mismatch++;
         results();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_rd <= 1'b0;
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
   endtask
   task automatic stop();
      @(posedge core_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
   endtask
   task automatic rdc(input logic [11:0] a, input logic [7:0] m, input logic [7:0] e,
      input string msg);
      @(posedge core_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(negedge core_clk);
      chk(reg_rdata & m, e, msg);
   endtask
   task automatic unl(input logic [7:0] d);
      wr(12'hf82, 8'h55);
      wr(12'hf82, 8'haa);
      wr(12'hf81, d);
      stop();
      @(negedge core_clk);
   endtask
   task automatic tbl(input logic r);
      @(posedge core_clk);
      table_read_op <= r;
      table_write_op <= !r;
      @(posedge core_clk);
      table_read_op <= 1'b0;
      table_write_op <= 1'b0;
      repeat (3) @(posedge core_clk);
   endtask
   task automatic idle_wait();
      int i;
      i = 0;
      @(negedge core_clk);
      while (busy !== 1'b0 && i < 40) begin
         @(negedge core_clk);
         i++;
      end
      chk({7'h00, busy}, 8'h00, "busy stuck");
   endtask
   task automatic t_regs();
      rdc(12'hf80, 8'hff, 8'h00, "data reset");
      rdc(12'hf81, 8'hf7, 8'h00, "ctrl reset");
      rdc(12'hff5, 8'hff, 8'h00, "latch reset");
      wr(12'hf82, 8'h5a);
      rdc(12'hf82, 8'hff, 8'h00, "key read");
      wr(12'hf7f, 8'hff);
      rdc(12'hf7f, 8'hff, 8'h00, "addr high");
      wr(12'hff7, 8'h22);
      wr(12'hff8, 8'hff);
      rdc(12'hff7, 8'hff, 8'h22, "ptr high");
      rdc(12'hff8, 8'hff, 8'h3f, "ptr upper");
      rdc(12'hf83, 8'hff, 8'h00, "unmapped");
   endtask
   task automatic t_eeprom();
      wr(12'hf7e, 8'h12);
      wr(12'hf80, 8'h3c);
      unl(8'h06);
      rdc(12'hf81, 8'h02, 8'h02, "go set");
      wr(12'hf81, 8'h04);
      stop();
      @(negedge core_clk);
      chk({7'h00, busy}, 8'h01, "go abort");
      idle_wait();
      rdc(12'hf81, 8'h02, 8'h00, "go clear");
      wr(12'hf80, 8'h00);
      wr(12'hf81, 8'h05);
      stop();
      idle_wait();
      rdc(12'hf81, 8'h01, 8'h00, "fetch clear");
      rdc(12'hf80, 8'hff, 8'h3c, "eeprom byte");
   endtask
   task automatic t_lock();
      wr(12'hf82, 8'h55);
      wr(12'hf80, 8'h00);
      wr(12'hf82, 8'haa);
      wr(12'hf81, 8'h06);
      rdc(12'hf81, 8'h02, 8'h00, "go no key");
      wr(12'hf82, 8'h55);
      wr(12'hf82, 8'haa);
      stop();
      wr(12'hf81, 8'h06);
      rdc(12'hf81, 8'h02, 8'h00, "go after gap");
      unl(8'h02);
      rdc(12'hf81, 8'h02, 8'h00, "go no enable");
   endtask
   task automatic t_flash();
      wr(12'hff6, 8'h07);
      wr(12'hff7, 8'h00);
      wr(12'hff8, 8'h00);
      wr(12'hff5, 8'ha5);
      stop();
      tbl(1'b0);
      unl(8'h86);
      idle_wait();
      wr(12'hff5, 8'h00);
      stop();
      tbl(1'b1);
      rdc(12'hff5, 8'hff, 8'ha5, "flash write");
      unl(8'h96);
      idle_wait();
      rdc(12'hf81, 8'h12, 8'h00, "erase end");
      tbl(1'b1);
      rdc(12'hff5, 8'hff, 8'hff, "flash erase");
   endtask
   task automatic t_config();
      unl(8'h46);
      chk({7'h00, busy}, 8'h00, "bad region");
      rdc(12'hf81, 8'h08, 8'h08, "error set");
      repeat (20) @(posedge core_clk);
      rdc(12'hf81, 8'h08, 8'h08, "error hold");
      wr(12'hf81, 8'h04);
      rdc(12'hf81, 8'h08, 8'h00, "error clear");
      wr(12'hf81, 8'h0c);
      rdc(12'hf81, 8'h08, 8'h08, "error by sw");
      wr(12'hff8, 8'h20);
      unl(8'h46);
      chk({7'h00, busy}, 8'h01, "config start");
      idle_wait();
      rdc(12'hf81, 8'h08, 8'h00, "error before abort");
      abort_req <= 1'b1;
      repeat (6) @(posedge core_clk);
      rdc(12'hf81, 8'h08, 8'h08, "reset abort");
   endtask
   initial begin
      repeat (6) @(posedge core_clk);
      resetn <= 1'b1;
      t_regs();
      t_eeprom();
      t_lock();
      t_flash();
      t_config();
      results();
   end
endmodule // nvm_access_control_bench
`default_nettype wire

// file: verification/nvmac_checker.sv
// port assertions for the nonvolatile memory access control block
`timescale 1ns/10ps
`default_nettype none
module nvmac_checker #(
   parameter int PROG_CYCLES = 8
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // register port
   input wire logic [11:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // table strobes, marker and status
   input wire logic table_read_op,
   input wire logic table_write_op,
   input wire logic write_aborted_by_reset,
   input wire logic busy
);
   localparam int PW = PROG_CYCLES + 4;
   wire start_wr = reg_wr && reg_addr == 12'hf81 && (reg_wdata[1] || reg_wdata[0]);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   sequence s_unlock;
      reg_wr && reg_addr == 12'hf82 && reg_wdata == 8'h55 ##1
      reg_wr && reg_addr == 12'hf82 && reg_wdata == 8'haa;
   endsequence
   sequence s_go(bit en);
      !busy && reg_wr && reg_addr == 12'hf81 && reg_wdata[7:6] == 2'b00
      && reg_wdata[1] && reg_wdata[2] == en;
   endsequence
   a_key_reads_zero: assert property (reg_rd && reg_addr == 12'hf82 |=> reg_rdata == 8'h00)
      else $error("unlock key read not zero");
   a_rdata_idle_zero: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data outside read cycle");
   a_unlock_go_busy: assert property (s_unlock ##1 s_go(1'b1) |=> busy)
      else $error("unlocked go did not start");
   a_no_enable_idle: assert property (s_unlock ##1 s_go(1'b0) |=> !busy [*2])
      else $error("go started without enable");
   a_prog_self_timed: assert property (s_unlock ##1 s_go(1'b1) |=> busy ##[1:PW] !busy)
      else $error("program did not end in time");
   a_busy_has_cause: assert property ($rose(busy) |-> $past(start_wr))
      else $error("busy rose without a start write");
   a_fetch_clears: assert property (!busy && start_wr && reg_wdata[1:0] == 2'b01
      |=> busy ##[1:4] !busy)
      else $error("fetch did not finish");
   a_reset_quiet: assert property ($rose(resetn) |-> !busy && reg_rdata == 8'h00)
      else $error("outputs active after reset");
endmodule // nvmac_checker
bind nvmac_top nvmac_checker #(.PROG_CYCLES(PROG_CYCLES)) u_chk (.core_clk(core_clk),
   .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .table_read_op(table_read_op),
   .table_write_op(table_write_op), .write_aborted_by_reset(write_aborted_by_reset),
   .busy(busy));
`default_nettype wire

// file: verification/nvmac_rst_model.sv
// reset controller stand-in driving the interrupted-write marker
`timescale 1ns/10ps
`default_nettype none
module nvmac_rst_model (
   // request from the bench
   input wire logic abort_req,
   // marker to the block
   output logic write_aborted_by_reset
);
   initial begin
      write_aborted_by_reset = 1'b0;
   end
   // marker moves off the clock grid, as an unsynchronised source would
   always @(abort_req) begin
      write_aborted_by_reset <= #37 abort_req;
   end
endmodule // nvmac_rst_model
`default_nettype wire
